/* File: hw/icu_pkg.sv */
// Shared constants, types and helpers for the smart card character engine
`default_nettype none
package icu_pkg;
  // ==========================================================================
  // Host register offsets
  localparam logic [3:0] ICU_OFS_CTRL = 4'h0;
  localparam logic [3:0] ICU_OFS_FCR = 4'h1;
  localparam logic [3:0] ICU_OFS_GUARD = 4'h2;
  localparam logic [3:0] ICU_OFS_DIVLO = 4'h3;
  localparam logic [3:0] ICU_OFS_DIVHI = 4'h4;
  localparam logic [3:0] ICU_OFS_DATA = 4'h5;
  localparam logic [3:0] ICU_OFS_USR = 4'h6;
  localparam logic [3:0] ICU_OFS_MSR = 4'h7;
  // ==========================================================================
  // Field positions
  localparam int ICU_B_DIR = 0;
  localparam int ICU_B_LCT = 1;
  localparam int ICU_B_SCHEME = 2;
  localparam int ICU_B_INVPAR = 3;
  localparam int ICU_FL_LSB = 0;
  localparam int ICU_RETRY_LSB = 3;
  localparam int ICU_B_FTE_A = 6;
  localparam int ICU_B_FTE_B = 7;
  localparam int ICU_B_TXRX = 0;
  localparam int ICU_B_PE = 1;
  localparam int ICU_B_OVR = 2;
  localparam int ICU_B_EA = 3;
  localparam int ICU_B_FE = 0;
  localparam int ICU_B_MSR_TXRX = 1;
  localparam int ICU_B_CONTROLLER_READY_FLAG = 2;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] ICU_CTRL_RST = 8'h00;
  localparam logic [7:0] ICU_FCR_RST = 8'h07;
  localparam logic [7:0] ICU_GUARD_RST = 8'h00;
  localparam logic [15:0] ICU_DIV_RST = 16'h0174;
  // ==========================================================================
  // Frame positions in tenths of an ETU, sub-bit tenths and whole-ETU bit indices
  localparam logic [11:0] ICU_T_ETU = 12'h00A;
  localparam logic [11:0] ICU_T_GUARD_STD = 12'h078;
  localparam logic [11:0] ICU_T_GUARD_CHR = 12'h076;
  localparam logic [11:0] ICU_T_GUARD_BLK = 12'h06C;
  localparam logic [11:0] ICU_T_ERR_END = 12'h073;
  localparam logic [3:0] ICU_SUB_MID = 4'h5;
  localparam logic [3:0] ICU_SUB_LAST = 4'h9;
  localparam logic [3:0] ICU_BIT_PAR = 4'h9;
  localparam logic [3:0] ICU_BIT_EVAL = 4'hA;
  localparam logic [3:0] ICU_BIT_TXCHK = 4'hB;
  // ==========================================================================
  // Early answer windows in card clock cycles, and receive FIFO depth
  localparam logic [9:0] ICU_EA_LO = 10'h0C8;
  localparam logic [9:0] ICU_EA_HI = 10'h170;
  localparam logic [9:0] ICU_EA_END = 10'h190;
  localparam int ICU_FIFO_MAX = 8;

  typedef enum logic [1:0] {
    ICU_IDLE = 2'b00,
    ICU_RX = 2'b01,
    ICU_RX_ERR = 2'b11,
    ICU_TX = 2'b10
  } icu_state_t;

  function automatic logic [11:0] icu_spacing(input logic [7:0] guard,
                                              input logic block);
    if (guard == 8'hFF)
      return block ? ICU_T_GUARD_BLK : ICU_T_GUARD_CHR;
    return ICU_T_GUARD_STD + 12'(guard) * ICU_T_ETU;
  endfunction

  function automatic logic icu_parity_ok(input logic [7:0] data,
                                         input logic par, input logic inv);
    return (^{data, par}) == inv;
  endfunction
endpackage
`default_nettype wire

/* File: hw/icu_uart_core.sv */
// Smart card character engine: receive FIFO and card line timing core
//
// Summary of operation
// - Extra guard register adds ETUs between sent start bits; reset gives 12.
// - Guard FFh spaces start bits 11.8 ETU, or 10.8 in block scheme.
// - After last character succeeds, hardware clears direction and last flag.
// - Final flagged transmission never sets the empty/full flag.
// - Empty flag set on entering transmit, cleared while data is held.
// - Standard mode: full flag at configured depth, cleared after a read.
// - Block scheme: first parity error sets parity flag, retry count ignored.
// - Even parity over eight bits plus parity; receive check inverted when selected.
// - Character scheme bad parity with retries left drives error 10.5-11.5.
// - Bad parity with retry counter at zero sets the parity error flag.
// - Character scheme: good character reloads retry counter with its programmed value.
// - Block scheme never drives an error signal.
// - Without threshold mode depth equals length field plus one.
// - Standard mode: character at full FIFO sets overrun, is discarded.
// - Reads give oldest character; FIFO flushed on entering receive.
// - Character scheme stores only passing characters; block stores all.
// - Threshold mode: length eight, full while occupancy exceeds field.
// - Threshold mode: character at full FIFO sets overrun and overwrites.
// - Start bit in early window sets early-answer flag and interrupt.
// - Start bit in first 200 reset-low cycles is ignored entirely.
`timescale 1ns/10ps
`default_nettype none

// ============================================================================
// Receive FIFO with depth limit and optional overwrite of newest entry
module icu_rx_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Control
  input wire logic flush,
  input wire logic [$clog2(D):0] limit,
  input wire logic overwrite,
  // Fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready,
  output logic [$clog2(D):0] count
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic push;
  logic pop;
  logic ovw;

  if ((1 << AW) != D) begin : g_bad_depth
    $error("icu_rx_fifo depth must be a power of two");
  end

  assign in_ready = count < limit;
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign ovw = in_valid && !in_ready && overwrite && out_valid;

  always_ff @(posedge clk) begin
    if (push)
      mem[wr_ptr] <= in_data;
    else if (ovw)
      mem[wr_ptr - AW'(1)] <= in_data;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push)
        wr_ptr <= wr_ptr + AW'(1);
      if (pop)
        rd_ptr <= rd_ptr + AW'(1);
      if (push && !pop)
        count <= count + (AW+1)'(1);
      else if (pop && !push)
        count <= count - (AW+1)'(1);
    end
  end
endmodule

// ============================================================================
// Core: host registers, card line framing, early answer detection
module icu_uart_core
  import icu_pkg::*;
#(
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Host register port
  input wire logic [3:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  // Card side
  input wire logic card_clk_pin,
  input wire logic card_reset_pin,
  input wire logic card_io_line_in,
  output logic card_io_line_out,
  output logic card_io_line_oe,
  // Host interrupt
  output logic irq
);
  localparam int CW = $clog2(DEPTH) + 1;

  if (DEPTH != ICU_FIFO_MAX) begin : g_bad_depth
    $error("icu_uart_core needs DEPTH of eight for the length field");
  end

  // ==========================================================================
  // Declarations
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic clk_prev, rst_prev, io_prev;
  logic cclk_en, io_fall, rst_lvl, rst_chg, io_lvl;
  logic [15:0] acc;
  logic [16:0] acc_sum;
  logic tick, step;
  logic [11:0] tpos;
  logic [3:0] sub, bidx;
  logic [7:0] ctrl, fifo_control_reg, guard;
  logic [15:0] etu_div;
  logic dir_prev, dir_fall;
  icu_state_t state;
  logic [7:0] hold, shift, rx_sh;
  logic hold_full, hold_last, shift_last, retx_pend, rx_par;
  logic hw_last_done, txrx_flag, pe, fifo_overflow_flag, ea, io_out_q;
  logic [2:0] retry_cnt;
  logic [9:0] ea_cnt;
  logic ea_arm, ea_win, ea_block, ea_hit;
  logic tx_go, rx_go, frame_start, tx_bit, eval, p_ok, char_mode;
  logic err_start, pe_set, push_req, ovr_set, rx_full, ft, pop;
  logic data_wr, usr_rd;
  logic [9:0] frame10;
  logic [CW-1:0] limit, f_count;
  logic f_in_ready, f_out_valid;
  logic [7:0] f_out, rd_mux;

  // ==========================================================================
  // Pin synchronisers and card clock edge
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1 <= 3'h7;
      sync2 <= 3'h7;
      clk_prev <= 1'b1;
      rst_prev <= 1'b1;
      io_prev <= 1'b1;
    end else begin
      sync1 <= {card_clk_pin, card_reset_pin, card_io_line_in};
      sync2 <= sync1;
      clk_prev <= sync2[2];
      rst_prev <= sync2[1];
      io_prev <= sync2[0];
    end
  end

  assign cclk_en = sync2[2] && !clk_prev;
  assign rst_lvl = sync2[1];
  assign rst_chg = rst_lvl ^ rst_prev;
  assign io_lvl = sync2[0];
  assign io_fall = io_prev && !io_lvl;

  // ==========================================================================
  // Tenth-of-ETU tick: adds ten per card clock, wraps at the divider
  assign acc_sum = {1'b0, acc} + 17'h0000A;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc <= 16'h0000;
      tick <= 1'b0;
      step <= 1'b0;
    end else begin
      tick <= 1'b0;
      step <= tick;
      if (cclk_en) begin
        if (acc_sum >= {1'b0, etu_div}) begin
          acc <= 16'(acc_sum - {1'b0, etu_div});
          tick <= 1'b1;
        end else begin
          acc <= acc_sum[15:0];
        end
      end
    end
  end

  // Frame position; saturates so the guard compare stays valid when idle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tpos <= 12'hFFF;
      sub <= 4'h0;
      bidx <= 4'hF;
    end else if (frame_start) begin
      tpos <= 12'h000;
      sub <= 4'h0;
      bidx <= 4'h0;
    end else if (tick) begin
      if (tpos != 12'hFFF)
        tpos <= tpos + 12'h001;
      if (sub == ICU_SUB_LAST) begin
        sub <= 4'h0;
        if (bidx != 4'hF)
          bidx <= bidx + 4'h1;
      end else begin
        sub <= sub + 4'h1;
      end
    end
  end

  // ==========================================================================
  // Host registers
  assign data_wr = bus_wr && bus_addr == ICU_OFS_DATA && ctrl[ICU_B_DIR];
  assign usr_rd = bus_rd && bus_addr == ICU_OFS_USR;
  assign pop = bus_rd && bus_addr == ICU_OFS_DATA && !ctrl[ICU_B_DIR];
  assign dir_fall = dir_prev && !ctrl[ICU_B_DIR];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= ICU_CTRL_RST;
      fifo_control_reg <= ICU_FCR_RST;
      guard <= ICU_GUARD_RST;
      etu_div <= ICU_DIV_RST;
      dir_prev <= 1'b0;
    end else begin
      dir_prev <= ctrl[ICU_B_DIR];
      if (bus_wr && bus_addr == ICU_OFS_CTRL) begin
        ctrl <= bus_wdata;
      end else if (hw_last_done) begin
        ctrl[ICU_B_DIR] <= 1'b0;
        ctrl[ICU_B_LCT] <= 1'b0;
      end
      if (bus_wr && bus_addr == ICU_OFS_FCR)
        fifo_control_reg <= bus_wdata;
      if (bus_wr && bus_addr == ICU_OFS_GUARD)
        guard <= bus_wdata;
      if (bus_wr && bus_addr == ICU_OFS_DIVLO)
        etu_div[7:0] <= bus_wdata;
      if (bus_wr && bus_addr == ICU_OFS_DIVHI)
        etu_div[15:8] <= bus_wdata;
    end
  end

  // Transmit holding byte; last flag captured at write time
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold <= 8'h00;
      hold_full <= 1'b0;
      hold_last <= 1'b0;
    end else if (data_wr) begin
      hold <= bus_wdata;
      hold_full <= 1'b1;
      hold_last <= ctrl[ICU_B_LCT];
    end else if (tx_go && !retx_pend) begin
      hold_full <= 1'b0;
    end
  end

  // ==========================================================================
  // Frame starts
  assign tx_go = state == ICU_IDLE && ctrl[ICU_B_DIR] &&
                 (retx_pend ? tpos >= ICU_T_GUARD_STD :
                  hold_full && tpos >= icu_spacing(guard,
                                                   ctrl[ICU_B_SCHEME]));
  assign rx_go = state == ICU_IDLE && !ctrl[ICU_B_DIR] && io_fall &&
                 !ea_block;
  assign frame_start = tx_go || rx_go;

  // Open drain line: drive low for a zero, release for a one
  assign frame10 = {^shift, shift, 1'b0};
  assign tx_bit = (bidx < 4'hA) ? frame10[bidx] : 1'b1;

  // Receive decision at 10.5 ETU
  assign char_mode = !ctrl[ICU_B_SCHEME];
  assign eval = state == ICU_RX && step && sub == ICU_SUB_MID &&
                bidx == ICU_BIT_EVAL;
  assign p_ok = icu_parity_ok(rx_sh, rx_par, ctrl[ICU_B_INVPAR]);
  assign err_start = eval && char_mode && !p_ok && retry_cnt != 3'h0;
  assign pe_set = eval && !p_ok &&
                  (!char_mode || retry_cnt == 3'h0);
  assign push_req = eval && (!char_mode || p_ok);

  // ==========================================================================
  // Link state machine
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ICU_IDLE;
      shift <= 8'h00;
      shift_last <= 1'b0;
      retx_pend <= 1'b0;
      rx_sh <= 8'h00;
      rx_par <= 1'b0;
      card_io_line_oe <= 1'b0;
      hw_last_done <= 1'b0;
    end else begin
      hw_last_done <= 1'b0;
      unique case (state)
        ICU_IDLE: begin
          card_io_line_oe <= 1'b0;
          if (tx_go) begin
            state <= ICU_TX;
            retx_pend <= 1'b0;
            if (!retx_pend) begin
              shift <= hold;
              shift_last <= hold_last;
            end
          end else if (rx_go) begin
            state <= ICU_RX;
          end
        end
        ICU_TX: begin
          card_io_line_oe <= !tx_bit;
          // Block scheme has no error slot, so the frame ends at 10 ETU
          if (step && sub == 4'h0 &&
              bidx == (char_mode ? ICU_BIT_TXCHK : ICU_BIT_EVAL)) begin
            state <= ICU_IDLE;
            if (char_mode && !io_lvl)
              retx_pend <= 1'b1;
            else if (shift_last)
              hw_last_done <= 1'b1;
          end
        end
        ICU_RX: begin
          if (step && sub == ICU_SUB_MID) begin
            if (bidx == 4'h0 && io_lvl)
              state <= ICU_IDLE;
            else if (bidx != 4'h0 && bidx < ICU_BIT_PAR)
              rx_sh <= {io_lvl, rx_sh[7:1]};
            else if (bidx == ICU_BIT_PAR)
              rx_par <= io_lvl;
            else if (eval) begin
              if (err_start) begin
                card_io_line_oe <= 1'b1;
                state <= ICU_RX_ERR;
              end else begin
                state <= ICU_IDLE;
              end
            end
          end
        end
        ICU_RX_ERR: begin
          if (step && tpos >= ICU_T_ERR_END) begin
            card_io_line_oe <= 1'b0;
            state <= ICU_IDLE;
          end
        end
      endcase
    end
  end

  // Retry counter
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n)
      retry_cnt <= ICU_FCR_RST[ICU_RETRY_LSB +: 3];
    else if (bus_wr && bus_addr == ICU_OFS_FCR)
      retry_cnt <= bus_wdata[ICU_RETRY_LSB +: 3];
    else if (eval && char_mode && p_ok)
      retry_cnt <= fifo_control_reg[ICU_RETRY_LSB +: 3];
    else if (err_start)
      retry_cnt <= retry_cnt - 3'h1;
  end

  // ==========================================================================
  // Early answer window
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ea_cnt <= 10'h000;
      ea_arm <= 1'b0;
    end else begin
      if (rst_chg)
        ea_cnt <= 10'h000;
      else if (cclk_en && ea_cnt != ICU_EA_END)
        ea_cnt <= ea_cnt + 10'h001;
      if (rst_chg && !rst_lvl)
        ea_arm <= 1'b1;
      else if (rst_lvl && ea_cnt == ICU_EA_END)
        ea_arm <= 1'b0;
    end
  end

  assign ea_win = ea_arm && ea_cnt < ICU_EA_HI &&
                  (rst_lvl || ea_cnt >= ICU_EA_LO);
  assign ea_block = ea_arm && !rst_lvl && ea_cnt < ICU_EA_LO;
  assign ea_hit = state == ICU_IDLE && !ctrl[ICU_B_DIR] && io_fall &&
                  ea_win;

  // ==========================================================================
  // Receive FIFO
  assign ft = fifo_control_reg[ICU_B_FTE_A] && fifo_control_reg[ICU_B_FTE_B];
  assign limit = ft ? CW'(DEPTH) :
                 CW'({1'b0, fifo_control_reg[ICU_FL_LSB +: 3]}) + CW'(1);
  assign rx_full = ft ? f_count > CW'(fifo_control_reg[ICU_FL_LSB +: 3]) :
                   f_count == limit;
  assign ovr_set = push_req && !f_in_ready;

  icu_rx_fifo #(
    .W(8),
    .D(DEPTH)
  ) u_fifo (
    .clk(core_clk),
    .arst_n(arst_n),
    .flush(dir_fall),
    .limit(limit),
    .overwrite(ft),
    .in_valid(push_req),
    .in_data(rx_sh),
    .in_ready(f_in_ready),
    .out_valid(f_out_valid),
    .out_data(f_out),
    .out_ready(pop),
    .count(f_count)
  );

  // ==========================================================================
  // Status flags; a new event beats a clearing read
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pe <= 1'b0;
      fifo_overflow_flag <= 1'b0;
      ea <= 1'b0;
      txrx_flag <= 1'b0;
      irq <= 1'b0;
    end else begin
      pe <= pe_set || (pe && !usr_rd);
      fifo_overflow_flag <= ovr_set || (fifo_overflow_flag && !usr_rd);
      ea <= ea_hit || (ea && !usr_rd);
      irq <= ea || (ft && rx_full && !ctrl[ICU_B_DIR]);
      if (ctrl[ICU_B_DIR]) begin
        if (!dir_prev)
          txrx_flag <= 1'b1;
        else if (data_wr)
          txrx_flag <= 1'b0;
        else if (tx_go && !retx_pend && !hold_last)
          txrx_flag <= 1'b1;
      end else begin
        txrx_flag <= rx_full;
      end
    end
  end

  // ==========================================================================
  // Read data
  always_comb begin
    rd_mux = 8'h00;
    unique case (bus_addr)
      ICU_OFS_CTRL: rd_mux = ctrl;
      ICU_OFS_FCR: rd_mux = fifo_control_reg;
      ICU_OFS_GUARD: rd_mux = guard;
      ICU_OFS_DIVLO: rd_mux = etu_div[7:0];
      ICU_OFS_DIVHI: rd_mux = etu_div[15:8];
      ICU_OFS_DATA: rd_mux = f_out_valid ? f_out : 8'h00;
      ICU_OFS_USR: begin
        rd_mux[ICU_B_TXRX] = txrx_flag;
        rd_mux[ICU_B_PE] = pe;
        rd_mux[ICU_B_OVR] = fifo_overflow_flag;
        rd_mux[ICU_B_EA] = ea;
      end
      ICU_OFS_MSR: begin
        rd_mux[ICU_B_FE] = !f_out_valid;
        rd_mux[ICU_B_MSR_TXRX] = txrx_flag;
        rd_mux[ICU_B_CONTROLLER_READY_FLAG] = state == ICU_IDLE;
      end
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_rdata <= 8'h00;
      io_out_q <= 1'b0;
    end else begin
      io_out_q <= 1'b0;
      if (bus_rd)
        bus_rdata <= rd_mux;
    end
  end

  assign card_io_line_out = io_out_q;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_guard_spacing: assert property (
    $rose(state == ICU_TX) && !$past(retx_pend) |->
      $past(tpos) >= (($past(guard) == 8'hFF) ?
        ($past(ctrl[ICU_B_SCHEME]) ? ICU_T_GUARD_BLK : ICU_T_GUARD_CHR) :
        ICU_T_GUARD_STD + 12'($past(guard)) * ICU_T_ETU))
    else $error("transmit start before guard spacing");
  a_last_clears: assert property (
    hw_last_done && !(bus_wr && bus_addr == ICU_OFS_CTRL) |=>
      !ctrl[ICU_B_DIR] && !ctrl[ICU_B_LCT])
    else $error("direction or last flag not cleared");
  a_last_no_flag: assert property (
    hw_last_done && !txrx_flag |=> !txrx_flag)
    else $error("empty flag raised after last character");
  a_err_pulse: assert property (
    err_start |=> card_io_line_oe [*3])
    else $error("error signal not driven");
  a_block_no_err: assert property (
    state == ICU_RX_ERR |-> char_mode)
    else $error("error signal in block scheme");
  a_pe_exhaust: assert property (
    eval && char_mode && !p_ok && retry_cnt == 3'h0 |=> pe)
    else $error("parity flag not set on exhausted retries");
  a_ovr_discard: assert property (
    push_req && !f_in_ready && !ft && !pop |=>
      fifo_overflow_flag && f_count == $past(f_count))
    else $error("overrun not flagged or FIFO changed");
  a_ea_flag: assert property (
    ea_hit |=> ea ##1 irq)
    else $error("early answer not flagged");
  a_ea_ignore: assert property (
    io_fall && ea_block |=> state == ICU_IDLE)
    else $error("start bit accepted in blocked window");
endmodule
`default_nettype wire

/* File: tb/icu_card_model.sv */
// Behavioural contact card on the open-drain I/O line
`timescale 1ns/10ps
`default_nettype none
module icu_card_model #(
  parameter int DIV = 20
) (
  // Card side
  input wire logic card_clk,
  input wire logic line,
  output logic drive_low
);
  logic err;
  logic [7:0] got;
  time t_prev;
  time gap;
  initial begin
    drive_low = 1'b0;
    t_prev = 0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge card_clk);
  endtask
  // Even parity unless spoiled on purpose
  task automatic send(input logic [7:0] d, input logic bad);
    logic [9:0] f;
    f = {^d ^ bad, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      drive_low = !f[i];
      tick(DIV);
    end
    drive_low = 1'b0;
    tick(DIV);
    err = !line;
    tick(DIV);
  endtask
  // Never signals an error, so every sent character succeeds
  task automatic recv();
    @(negedge line);
    gap = $time - t_prev;
    t_prev = $time;
    tick(DIV / 2);
    for (int i = 0; i < 8; i++) begin
      tick(DIV);
      got[i] = line;
    end
    tick(DIV);
  endtask
endmodule
`default_nettype wire

/* File: tb/test_icu_uart_core.sv */
// Self-checking bench for the smart card character engine
`timescale 1ns/10ps
`default_nettype none
module test_icu_uart_core;
  import icu_pkg::*;
  localparam int DIV = 10;
  logic core_clk, arst_n, bus_wr, bus_rd, card_clk_pin, card_low, card_rst;
  logic [3:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata, rd_val;
  logic io_out, io_oe, irq, line;
  int failures, n_tests;
  // Pulled up unless a party pulls low
  assign line = !((io_oe && !io_out) || card_low);
  icu_uart_core #(.DEPTH(8)) icu_uart_core_inst (.core_clk(core_clk),
    .arst_n(arst_n), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .card_clk_pin(card_clk_pin), .card_reset_pin(card_rst),
    .card_io_line_in(line), .card_io_line_out(io_out),
    .card_io_line_oe(io_oe), .irq(irq));
  icu_card_model #(.DIV(DIV)) icu_card_model_inst (.card_clk(card_clk_pin),
    .line(line), .drive_low(card_low));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    card_clk_pin = 1'b0;
    forever #80 card_clk_pin = ~card_clk_pin;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge core_clk);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge core_clk);
    bus_wr = 1'b0;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [3:0] a);
    @(negedge core_clk);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge core_clk);
    bus_rd = 1'b0;
    @(negedge core_clk);
    rd_val = bus_rdata;
  endtask
  task automatic chk(input logic [3:0] a, input logic [7:0] m,
                     input logic [7:0] e);
    rd(a);
    cmp(rd_val & m, e);
  endtask
  // Holding byte is single, so wait for it to drain before the next write
  task automatic put(input logic [7:0] d);
    rd(ICU_OFS_MSR);
    for (int i = 0; i < 2000 && !rd_val[ICU_B_MSR_TXRX]; i++)
      rd(ICU_OFS_MSR);
    cmp(rd_val & 8'h02, 8'h02);
    wr(ICU_OFS_DATA, d);
  endtask
  task automatic card(input logic [7:0] d, input logic bad, input logic e);
    icu_card_model_inst.send(d, bad);
    cmp(8'(icu_card_model_inst.err), 8'(e));
  endtask
  task automatic rx2();
    icu_card_model_inst.recv();
    icu_card_model_inst.recv();
  endtask
  // Start-to-start gap in tenths of an ETU, two and a half card clocks of slack
  task automatic near(input int t);
    cmp(8'(icu_card_model_inst.gap > t * DIV * 16 - 400 &&
           icu_card_model_inst.gap < t * DIV * 16 + 400), 8'h01);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #600000;
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict();
  end
  initial begin
    arst_n = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 4'h0;
    bus_wdata = 8'h00;
    card_rst = 1'b1;
    failures = 0;
    n_tests = 0;
    repeat (8) @(negedge core_clk);
    arst_n = 1'b1;
    chk(ICU_OFS_GUARD, 8'hFF, 8'h00);
    chk(ICU_OFS_MSR, 8'h01, 8'h01);
    wr(ICU_OFS_DIVLO, 8'(DIV));
    wr(ICU_OFS_DIVHI, 8'h00);
    $display("test reset done");
    wr(ICU_OFS_FCR, 8'h01);
    card(8'hA1, 1'b0, 1'b0);
    card(8'h5C, 1'b0, 1'b0);
    chk(ICU_OFS_USR, 8'h01, 8'h01);
    card(8'h33, 1'b0, 1'b0);
    chk(ICU_OFS_USR, 8'h05, 8'h05);
    chk(ICU_OFS_DATA, 8'hFF, 8'hA1);
    chk(ICU_OFS_MSR, 8'h03, 8'h00);
    chk(ICU_OFS_DATA, 8'hFF, 8'h5C);
    chk(ICU_OFS_MSR, 8'h01, 8'h01);
    $display("test fifo done");
    wr(ICU_OFS_FCR, 8'h09);
    card(8'h77, 1'b1, 1'b1);
    card(8'h12, 1'b0, 1'b0);
    card(8'h77, 1'b1, 1'b1);
    card(8'h77, 1'b1, 1'b0);
    chk(ICU_OFS_USR, 8'h02, 8'h02);
    chk(ICU_OFS_DATA, 8'hFF, 8'h12);
    chk(ICU_OFS_MSR, 8'h01, 8'h01);
    $display("test retry done");
    wr(ICU_OFS_CTRL, 8'h08);
    card(8'h5A, 1'b1, 1'b0);
    chk(ICU_OFS_DATA, 8'hFF, 8'h5A);
    wr(ICU_OFS_CTRL, 8'h04);
    wr(ICU_OFS_FCR, 8'h09);
    card(8'h3C, 1'b1, 1'b0);
    chk(ICU_OFS_USR, 8'h02, 8'h02);
    chk(ICU_OFS_DATA, 8'hFF, 8'h3C);
    $display("test parity done");
    wr(ICU_OFS_GUARD, 8'h02);
    wr(ICU_OFS_CTRL, 8'h01);
    fork
      rx2();
      begin
        put(8'h81);
        put(8'h42);
      end
    join
    near(140);
    wr(ICU_OFS_GUARD, 8'hFF);
    wr(ICU_OFS_CTRL, 8'h05);
    fork
      rx2();
      begin
        put(8'h81);
        wr(ICU_OFS_CTRL, 8'h07);
        put(8'hC3);
      end
    join
    near(108);
    cmp(icu_card_model_inst.got, 8'hC3);
    repeat (3 * DIV * 20) @(negedge core_clk);
    chk(ICU_OFS_CTRL, 8'h03, 8'h00);
    chk(ICU_OFS_USR, 8'h01, 8'h00);
    chk(ICU_OFS_MSR, 8'h01, 8'h01);
    $display("test transmit done");
    wr(ICU_OFS_FCR, 8'hC1);
    card(8'h11, 1'b0, 1'b0);
    cmp(8'(irq), 8'h00);
    card(8'h22, 1'b0, 1'b0);
    cmp(8'(irq), 8'h01);
    chk(ICU_OFS_USR, 8'h01, 8'h01);
    chk(ICU_OFS_DATA, 8'hFF, 8'h11);
    cmp(8'(irq), 8'h00);
    chk(ICU_OFS_DATA, 8'hFF, 8'h22);
    $display("test threshold done");
    card_rst = 1'b0;
    repeat (100) @(posedge card_clk_pin);
    card(8'h00, 1'b0, 1'b0);
    chk(ICU_OFS_USR, 8'h08, 8'h00);
    chk(ICU_OFS_MSR, 8'h01, 8'h01);
    card_rst = 1'b1;
    repeat (10) @(posedge card_clk_pin);
    card(8'hA5, 1'b0, 1'b0);
    cmp(8'(irq), 8'h01);
    chk(ICU_OFS_USR, 8'h08, 8'h08);
    chk(ICU_OFS_DATA, 8'hFF, 8'hA5);
    $display("test early answer done");
    print_verdict();
  end
endmodule
`default_nettype wire
